// ===== logic/nfc_reader_anticollision_framer.sv
// transmit fifo and reader framer for anticollision and sync-word frames
`timescale 1ns/1ps

module framer_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    rd_reg, rd_next;
  logic [AW-1:0]    wr_reg, wr_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem_reg[rd_reg];

  always_comb
  begin
    push     = in_valid && in_ready;
    pop      = out_valid && out_ready;
    rd_next  = pop ? ((rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + AW'(1)) : rd_reg;
    wr_next  = push ? ((wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + AW'(1)) : wr_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_reg  <= '0;
      wr_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      rd_reg  <= rd_next;
      wr_reg  <= wr_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end
endmodule : framer_fifo

////////////////////////////////////////////////////////////////////////////////

module nfc_reader_anticollision_framer
  import nfc_framer_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire cfg_t       cfg,
  input  wire cmd_t       cmd,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] host_data,
  input  wire logic       host_valid,
  output logic            host_ready,
  output logic            tx_bit,
  output logic            tx_strobe,
  input  wire logic       rx_bit,
  input  wire logic       rx_bit_valid,
  input  wire logic       rx_coll,
  input  wire logic       rx_end,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic [2:0]      rx_last_bits,
  output logic [7:0]      rx_count,
  output logic            rx_active,
  output logic            busy,
  output irq_t            irq
);

  typedef struct packed {
    state_t      st;
    phase_t      ph;
    logic [6:0]  bl;
    logic [8:0]  sh;
    logic        par;
    logic        crc_on;
    logic [15:0] crc;
    logic [7:0]  left;
    logic        with_crc;
    logic        msb;
    logic [7:0]  mrt_cnt;
    logic [15:0] nrt_cnt;
    logic        heard;
    logic [3:0]  rcnt;
    logic [15:0] rsh;
    logic        rcol;
    logic        zeros;
    logic        hunt_ok;
    logic        got_len;
    logic [8:0]  rrem;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic [2:0]  rx_last_bits;
    logic [7:0]  rx_count;
    logic        tx_bit;
    logic        tx_strobe;
    irq_t        irq;
  } fr_t;

  fr_t              r, n;
  logic [7:0]       fifo_data;
  logic             fifo_valid;
  logic             pop;
  logic             fin;
  logic [7:0]       rbyte;
  logic [ACC_W-1:0] acc_reg, acc_next;
  logic [ACC_W:0]   acc_sum;
  logic [6:0]       fcc_reg, fcc_next;
  logic [6:0]       bit_mask;
  logic             fc_tick;
  logic             bit_tick;
  logic             step_tick;

  framer_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (host_data),
    .in_valid  (host_valid),
    .in_ready  (host_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (pop)
  );

  //////////////////////////////////////////////////////////////////////////////
  // fc enable from the system clock, bit and half-step enables from fc

  always_comb
  begin
    acc_sum  = {1'b0, acc_reg} + (ACC_W+1)'(FC_HZ);
    fc_tick  = acc_sum >= (ACC_W+1)'(CLK_HZ);
    acc_next = fc_tick ? ACC_W'(acc_sum - (ACC_W+1)'(CLK_HZ)) : ACC_W'(acc_sum);
    bit_mask = !cfg.sync_mode ? 7'(BIT_FC_106 - 1) :
               cfg.rate_424   ? 7'(BIT_FC_424 - 1) : 7'(BIT_FC_212 - 1);
    bit_tick  = fc_tick && ((fcc_reg & bit_mask) == bit_mask);
    step_tick = fc_tick && (fcc_reg[5:0] == 6'(HALF_STEP_FC - 1));
    fcc_next  = fc_tick ? fcc_reg + 7'h01 : fcc_reg;
    if (r.st == S_IDLE)
      fcc_next = '0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc_reg <= '0;
      fcc_reg <= '0;
    end
    else
    begin
      acc_reg <= acc_next;
      fcc_reg <= fcc_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // framer

  always_comb
  begin
    n            = r;
    pop          = 1'b0;
    fin          = 1'b0;
    rbyte        = {r.rsh[6:0], rx_bit};
    n.irq        = '0;
    n.rx_valid   = 1'b0;
    n.tx_strobe  = 1'b0;
    unique case (r.st)
      S_IDLE:
      begin
        if (cmd_valid && cmd != CMD_NONE)
        begin
          n.st       = S_TX;
          n.msb      = cfg.sync_mode;
          n.crc      = cfg.sync_mode ? CRC_S_INIT : CRC_A_INIT;
          n.with_crc = cmd == CMD_TX_CRC;
          n.left     = cfg.tx_byte_count;
          n.crc_on   = 1'b0;
          n.par      = 1'b0;
          n.sh       = '0;
          n.bl       = '0;
          n.ph       = P_PAY;
          if (cmd == CMD_REQA || cmd == CMD_WUPA)
          begin
            n.sh = {1'b0, (cmd == CMD_REQA) ? REQA_CODE : WUPA_CODE};
            n.bl = SHORT_BITS;
            n.ph = P_END;
          end
          else if (cfg.sync_mode)
          begin
            n.bl = pre_len({cfg.preamble_len_sel_hi, cfg.preamble_len_sel_lo});
            n.ph = P_SYNC1;
          end
        end
      end
      S_TX:
      begin
        if (r.bl != '0 && bit_tick)
        begin
          n.tx_bit    = r.sh[0];
          n.tx_strobe = 1'b1;
          n.sh        = r.sh >> 1;
          n.bl        = r.bl - 7'h01;
          if (r.crc_on && !(r.par && r.bl == 7'h01))
            n.crc = crc_step(r.crc, r.sh[0], r.msb);
        end
        else if (r.bl == '0)
        begin
          n.crc_on = 1'b1;
          n.par    = !r.msb;
          n.bl     = r.msb ? BYTE_BITS : BYTE_BITS + 7'h01;
          unique case (r.ph)
            P_SYNC1:
            begin
              n.crc_on = 1'b0;
              n.sh     = frame_byte(SYNC_FIRST, 1'b1);
              n.ph     = P_SYNC2;
            end
            P_SYNC2:
            begin
              n.crc_on = 1'b0;
              n.sh     = frame_byte(SYNC_SECOND, 1'b1);
              n.ph     = P_LEN;
            end
            P_LEN:
            begin
              n.sh = frame_byte(cfg.tx_byte_count + 8'h01, 1'b1);
              n.ph = P_PAY;
            end
            P_PAY:
            begin
              if (r.left == '0)
              begin
                n.bl = '0;
                n.ph = r.with_crc ? P_CRC1 : P_END;
              end
              else if (fifo_valid)
              begin
                pop    = 1'b1;
                n.left = r.left - 8'h01;
                n.sh   = frame_byte(fifo_data, r.msb);
                if (r.left == 8'h01)
                  n.ph = r.with_crc ? P_CRC1 : P_END;
                if (r.left == 8'h01 && !r.msb && !r.with_crc && cfg.tx_last_bits != '0)
                begin
                  n.bl  = {4'h0, cfg.tx_last_bits};
                  n.par = 1'b0;
                end
              end
              else
                n.bl = '0;
            end
            P_CRC1:
            begin
              n.crc_on = 1'b0;
              n.sh     = frame_byte(r.msb ? r.crc[15:8] : r.crc[7:0], r.msb);
              n.ph     = P_CRC2;
            end
            P_CRC2:
            begin
              n.crc_on = 1'b0;
              n.sh     = frame_byte(r.msb ? r.crc[7:0] : r.crc[15:8], r.msb);
              n.ph     = P_END;
            end
            P_END:
            begin
              n.bl          = '0;
              n.irq.tx_done = 1'b1;
              n.st          = S_MASK;
              n.crc         = r.msb ? CRC_S_INIT : CRC_A_INIT;
              n.mrt_cnt     = '0;
              n.nrt_cnt     = '0;
              n.heard       = 1'b0;
              n.rcnt        = '0;
              n.rsh         = 16'hFFFF;
              n.rcol        = 1'b0;
              n.zeros       = 1'b0;
              n.hunt_ok     = 1'b0;
              n.got_len     = 1'b0;
              n.rx_count    = '0;
            end
            default:
              n.ph = P_END;
          endcase
        end
      end
      S_MASK:
      begin
        if (step_tick)
          n.mrt_cnt = r.mrt_cnt + 8'h01;
        if (r.mrt_cnt >= cfg.mask_receive_timer)
          n.st = S_RX;
      end
      S_RX:
      begin
        if (rx_end)
        begin
          fin = 1'b1;
          if (!r.msb && r.rcnt != '0)
          begin
            n.rx_data      = r.rsh[15:8] >> (4'h8 - r.rcnt);
            n.rx_last_bits = r.rcnt[2:0];
            n.rx_valid     = 1'b1;
            n.rx_count     = r.rx_count + 8'h01;
          end
          if (r.msb)
            n.irq.framing_err = 1'b1;
        end
        else if (rx_bit_valid && r.msb)
        begin
          n.heard = 1'b1;
          n.rsh   = {r.rsh[14:0], rx_bit};
          if (!r.hunt_ok)
          begin
            if (r.rsh == '0)
              n.zeros = 1'b1;
            if (r.zeros && {r.rsh[14:0], rx_bit} == {SYNC_FIRST, SYNC_SECOND})
              n.hunt_ok = 1'b1;
          end
          else
          begin
            n.crc  = crc_step(r.crc, rx_bit, 1'b1);
            n.rcnt = r.rcnt + 4'h1;
            if (r.rcnt == 4'h7)
            begin
              n.rcnt = '0;
              n.rrem = r.rrem - 9'h001;
              if (!r.got_len)
              begin
                n.got_len = 1'b1;
                n.rrem    = {1'b0, rbyte} + 9'h001;
                if (rbyte < 8'h02)
                begin
                  n.irq.framing_err = 1'b1;
                  fin               = 1'b1;
                end
              end
              if (!r.got_len || r.rrem > 9'h002)
              begin
                n.rx_data      = rbyte;
                n.rx_last_bits = '0;
                n.rx_valid     = 1'b1;
                n.rx_count     = r.rx_count + 8'h01;
              end
              if (r.got_len && r.rrem == 9'h001)
                fin = 1'b1;
            end
          end
        end
        else if (rx_bit_valid)
        begin
          n.heard = 1'b1;
          if (r.rcnt == 4'h8)
          begin
            n.rcnt         = '0;
            n.rcol         = 1'b0;
            n.rx_data      = r.rsh[15:8];
            n.rx_last_bits = '0;
            n.rx_valid     = 1'b1;
            n.rx_count     = r.rx_count + 8'h01;
            if (!r.rcol && rx_bit != ~^r.rsh[15:8])
              n.irq.parity_err = 1'b1;
          end
          else
          begin
            n.rsh  = {rx_bit, r.rsh[15:1]};
            n.rcnt = r.rcnt + 4'h1;
            n.crc  = crc_step(r.crc, rx_bit, 1'b0);
            if (rx_coll)
            begin
              n.rcol = 1'b1;
              if (cfg.coll_tolerant)
                n.irq.collision = 1'b1;
              else
                n.irq.framing_err = 1'b1;
            end
          end
        end
      end
    endcase
    if ((r.st == S_MASK || r.st == S_RX) && !r.heard && cfg.no_response_timer != '0)
    begin
      if (step_tick)
        n.nrt_cnt = r.nrt_cnt + 16'h0001;
      if (r.nrt_cnt >= cfg.no_response_timer)
      begin
        n.irq.no_response = 1'b1;
        n.st              = S_IDLE;
      end
    end
    if (fin)
    begin
      n.st          = S_IDLE;
      n.irq.rx_done = 1'b1;
      if ((r.msb || !cfg.rx_no_crc) && n.crc != '0)
        n.irq.crc_err = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end

  assign tx_bit       = r.tx_bit;
  assign tx_strobe    = r.tx_strobe;
  assign rx_data      = r.rx_data;
  assign rx_valid     = r.rx_valid;
  assign rx_last_bits = r.rx_last_bits;
  assign rx_count     = r.rx_count;
  assign rx_active    = r.st == S_RX;
  assign busy         = r.st != S_IDLE;
  assign irq          = r.irq;
endmodule : nfc_reader_anticollision_framer

// ===== logic/nfc_framer_pkg.sv
// constants, types and helpers shared by the reader anticollision framer
package nfc_framer_pkg;

  localparam int unsigned CLK_HZ       = 40000000;
  localparam int unsigned FC_HZ        = 13560000;
  localparam int unsigned ACC_W        = 26;
  localparam int unsigned HALF_STEP_FC = 64;
  localparam int unsigned BIT_FC_106   = 128;
  localparam int unsigned BIT_FC_212   = 64;
  localparam int unsigned BIT_FC_424   = 32;
  localparam logic [7:0]  SYNC_FIRST   = 8'hB2;
  localparam logic [7:0]  SYNC_SECOND  = 8'h4D;
  localparam logic [7:0]  REQA_CODE    = 8'h26;
  localparam logic [7:0]  WUPA_CODE    = 8'h52;
  localparam logic [6:0]  SHORT_BITS   = 7'h07;
  localparam logic [6:0]  BYTE_BITS    = 7'h08;
  localparam logic [15:0] CRC_A_INIT   = 16'h6363;
  localparam logic [15:0] CRC_S_INIT   = 16'h0000;
  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam logic [15:0] CRC_POLY_REF = 16'h8408;
  localparam logic [6:0]  PRE_LEN_0    = 7'h30;
  localparam logic [6:0]  PRE_LEN_1    = 7'h50;
  localparam logic [6:0]  PRE_LEN_2    = 7'h60;
  localparam logic [6:0]  PRE_LEN_3    = 7'h78;

  typedef enum logic [2:0] {
    CMD_NONE     = 3'h0,
    CMD_TX_CRC   = 3'h1,
    CMD_TX_NOCRC = 3'h2,
    CMD_REQA     = 3'h3,
    CMD_WUPA     = 3'h4
  } cmd_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_TX   = 2'h1,
    S_MASK = 2'h2,
    S_RX   = 2'h3
  } state_t;

  typedef enum logic [2:0] {
    P_SYNC1 = 3'h0,
    P_SYNC2 = 3'h1,
    P_LEN   = 3'h2,
    P_PAY   = 3'h3,
    P_CRC1  = 3'h4,
    P_CRC2  = 3'h5,
    P_END   = 3'h6
  } phase_t;

  typedef struct packed {
    logic        sync_mode;
    logic        rate_424;
    logic        coll_tolerant;
    logic        rx_no_crc;
    logic        preamble_len_sel_hi;
    logic        preamble_len_sel_lo;
    logic [7:0]  tx_byte_count;
    logic [2:0]  tx_last_bits;
    logic [7:0]  mask_receive_timer;
    logic [15:0] no_response_timer;
  } cfg_t;

  typedef struct packed {
    logic tx_done;
    logic rx_done;
    logic no_response;
    logic collision;
    logic framing_err;
    logic parity_err;
    logic crc_err;
  } irq_t;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b,
                                           input logic msb_first);
    if (msb_first)
      crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
    else
      crc_step = {1'b0, c[15:1]} ^ ((c[0] ^ b) ? CRC_POLY_REF : 16'h0000);
  endfunction : crc_step

  // byte as shifted out lsb first: reversed for msb-first, odd parity appended otherwise
  function automatic logic [8:0] frame_byte(input logic [7:0] b, input logic msb_first);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r[i] = b[7-i];
    frame_byte = msb_first ? {1'b0, r} : {~^b, b};
  endfunction : frame_byte

  function automatic logic [6:0] pre_len(input logic [1:0] sel);
    case (sel)
      2'h0:    pre_len = PRE_LEN_0;
      2'h1:    pre_len = PRE_LEN_1;
      2'h2:    pre_len = PRE_LEN_2;
      default: pre_len = PRE_LEN_3;
    endcase
  endfunction : pre_len

endpackage : nfc_framer_pkg

// ===== tb/nfc_framer_monitor.sv
// port checker for the reader framer
`timescale 1ns/1ps

module nfc_framer_monitor
  import nfc_framer_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire cfg_t cfg,
  input wire cmd_t cmd,
  input wire logic cmd_valid,
  input wire logic tx_bit,
  input wire logic tx_strobe,
  input wire logic rx_valid,
  input wire logic rx_active,
  input wire logic busy,
  input wire irq_t irq
);
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  cmd_t        lat_reg;
  cmd_t        lat_next;
  logic        take;

  assign take = cmd_valid && (cmd != CMD_NONE) && !busy;

  // strobes counted since the last accepted command
  always_comb
  begin
    cnt_next = tx_strobe ? cnt_reg + 12'h001 : cnt_reg;
    lat_next = lat_reg;
    if (take)
    begin
      cnt_next = 12'h000;
      lat_next = cmd;
    end
  end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt_reg <= 12'h000;
      lat_reg <= CMD_NONE;
    end
    else
    begin
      cnt_reg <= cnt_next;
      lat_reg <= lat_next;
    end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  AST_BUSY_ON_CMD: assert property (take |=> busy)
    else $error("command not taken");
  AST_IDLE_QUIET: assert property (!busy |-> !tx_strobe && !rx_active)
    else $error("activity while idle");
  AST_STROBE_GAP: assert property (tx_strobe |=> !tx_strobe [*8])
    else $error("bit strobes too close");
  AST_TXDONE_MASKED: assert property (irq.tx_done |-> busy && !rx_active)
    else $error("receiver open at end of transmit");
  AST_TXDONE_LAST_BIT: assert property (irq.tx_done |-> $past(tx_strobe))
    else $error("end of transmit not after last bit");
  AST_NO_RX_IDLE: assert property (!busy && !$past(busy) |-> !rx_valid)
    else $error("receive data while idle");
  AST_TOLERANT: assert property (cfg.coll_tolerant && !cfg.sync_mode |-> !irq.framing_err)
    else $error("framing error with tolerant flag");
  AST_SHORT_FRAME: assert property
    (irq.tx_done && (lat_reg == CMD_REQA || lat_reg == CMD_WUPA) |-> cnt_reg == 12'h007)
    else $error("short frame not seven bits");
  AST_PREAMBLE_ZERO: assert property
    (tx_strobe && cfg.sync_mode && lat_reg == CMD_TX_CRC && cnt_reg < 12'h030 |-> !tx_bit)
    else $error("preamble bit not zero");
  AST_BUSY_HOLD: assert property (busy |=> busy || irq.rx_done || irq.no_response)
    else $error("busy dropped without end event");

  COV_COLL: cover property (irq.collision);
  COV_NRT: cover property (irq.no_response);
  COV_SYNC: cover property (irq.tx_done && cfg.sync_mode);
  COV_PAR: cover property (irq.parity_err);
endmodule : nfc_framer_monitor

bind nfc_reader_anticollision_framer nfc_framer_monitor i_mon (
  .clk(clk), .rst(rst), .cfg(cfg), .cmd(cmd), .cmd_valid(cmd_valid), .tx_bit(tx_bit),
  .tx_strobe(tx_strobe), .rx_valid(rx_valid), .rx_active(rx_active), .busy(busy), .irq(irq)
);

// ===== tb/nfc_tag_model.sv
// tag answering the reader at 106 kb/s
`timescale 1ns/1ps

module nfc_tag_model #(
  parameter int BIT_CLKS = 378
) (
  input  wire logic clk,
  output logic      rx_bit,
  output logic      rx_bit_valid,
  output logic      rx_coll,
  output logic      rx_end
);
  initial
  begin
    rx_bit = 1'h0;
    rx_bit_valid = 1'h0;
    rx_coll = 1'h0;
    rx_end = 1'h0;
  end

  // byte lsb first, odd parity, optional collision and bad parity
  task automatic send(input logic [7:0] b, input int cpos, input logic bad, input int nb);
    logic [8:0] f;
    f = {~^b ^ bad, b};
    for (int i = 0; i < nb; i++)
    begin
      repeat (BIT_CLKS - 1) @(negedge clk);
      rx_bit <= f[i];
      rx_bit_valid <= 1'h1;
      rx_coll <= (i == cpos);
      @(negedge clk);
      rx_bit <= ~f[i];
      rx_bit_valid <= 1'h0;
      rx_coll <= 1'h0;
    end
  endtask : send

  task automatic finish();
    repeat (BIT_CLKS) @(negedge clk);
    rx_end <= 1'h1;
    @(negedge clk);
    rx_end <= 1'h0;
  endtask : finish
endmodule : nfc_tag_model

// ===== tb/nfc_reader_anticollision_framer_test.sv
// self-checking bench for the reader framer
`timescale 1ns/1ps

module nfc_reader_anticollision_framer_test
  import nfc_framer_pkg::*;
;
  localparam int FDT_CLKS = 3646;
  localparam int PRE[4] = '{48, 80, 96, 120};
  logic clk = 1'h0;
  logic rst = 1'h1;
  cfg_t cfg;
  cmd_t cmd;
  logic cmd_valid, host_valid, host_ready, tx_bit, tx_strobe, rx_valid, rx_active, busy;
  logic rx_bit, rx_bit_valid, rx_coll, rx_end;
  logic [7:0] host_data, rx_data, rx_count;
  irq_t irq;
  logic [6:0] seen;
  logic [2:0] rx_last_bits;
  logic txq[$];
  logic exq[$];
  logic [7:0] rxq[$];
  int error_cnt = 0;
  int checks = 0;

  always #12.5 clk = ~clk;

  nfc_reader_anticollision_framer #(.FIFO_DEPTH(4)) i_dut (
    .clk(clk), .rst(rst), .cfg(cfg), .cmd(cmd), .cmd_valid(cmd_valid),
    .host_data(host_data), .host_valid(host_valid), .host_ready(host_ready),
    .tx_bit(tx_bit), .tx_strobe(tx_strobe), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
    .rx_coll(rx_coll), .rx_end(rx_end), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_last_bits(rx_last_bits), .rx_count(rx_count), .rx_active(rx_active),
    .busy(busy), .irq(irq)
  );

  nfc_tag_model #(.BIT_CLKS(378)) i_tag (
    .clk(clk), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_coll(rx_coll),
    .rx_end(rx_end)
  );

  // pulses gathered at the edge they stand for
  always @(posedge clk)
    if (!rst)
    begin
      if (tx_strobe)
        txq.push_back(tx_bit);
      if (rx_valid)
        rxq.push_back(rx_data);
      seen = seen | irq;
    end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // event bit of seen, or 7 for idle
  task automatic wait_irq(input int b, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      @(negedge clk);
      if (b == 7 ? !busy : seen[b])
        return;
    end
    error_cnt++;
    $display("[FAIL] wait_%0d expected 1 seen 0", b);
    report_and_stop();
  endtask : wait_irq

  task automatic run_cmd(input cmd_t c);
    txq.delete();
    rxq.delete();
    seen = 7'h00;
    @(negedge clk);
    cmd = c;
    cmd_valid = 1'h1;
    @(negedge clk);
    cmd = CMD_NONE;
    cmd_valid = 1'h0;
    chk("busy", busy, 1);
  endtask : run_cmd

  task automatic push_bits(input logic [7:0] v, input int n, input bit msb);
    for (int i = 0; i < n; i++)
      exq.push_back(msb ? v[7-i] : v[i]);
  endtask : push_bits

  task automatic cmp_tx();
    chk("tx_bits", txq.size(), exq.size());
    foreach (exq[i])
      if (i < txq.size())
        chk("tx_bit", txq[i], exq[i]);
    exq.delete();
  endtask : cmp_tx

  task automatic put_byte(input logic [7:0] b);
    @(negedge clk);
    chk("host_ready", host_ready, 1);
    host_data = b;
    host_valid = 1'h1;
    @(negedge clk);
    host_valid = 1'h0;
  endtask : put_byte

  task automatic push_a(input logic [7:0] v);
    push_bits(v, 8, 0);
    exq.push_back(~^v);
  endtask : push_a

  // a: reflected crc of 14443A frames, else msb-first crc of sync-word frames
  function automatic logic [15:0] crc_calc(input logic [7:0] q[$], input bit a);
    logic [15:0] c;
    c = a ? 16'h6363 : 16'h0000;
    foreach (q[j])
      for (int i = 0; i < 8; i++)
        if (a)
          c = {1'h0, c[15:1]} ^ ((c[0] ^ q[j][i]) ? 16'h8408 : 16'h0000);
        else
          c = {c[14:0], 1'h0} ^ ((c[15] ^ q[j][7-i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction : crc_calc

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int n;
    int t;
    logic [7:0] b;
    logic [15:0] crc;
    logic [7:0] pay[$];
    void'($urandom(32'h985B8783));
    cfg = '0;
    cmd = CMD_NONE;
    cmd_valid = 1'h0;
    host_data = 8'h00;
    host_valid = 1'h0;
    seen = 7'h00;
    repeat (16) @(negedge clk);
    rst = 1'h0;
    chk("reset", {host_ready, busy, tx_strobe, irq}, 10'h200);
    for (int k = 0; k < 2; k++)
    begin
      cfg = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 8'h00, 3'h0, 8'h10, 16'h0100};
      b = 8'($urandom);
      push_bits(k ? WUPA_CODE : REQA_CODE, 7, 0);
      run_cmd(k ? CMD_WUPA : CMD_REQA);
      wait_irq(6, 4000);
      cmp_tx();
      repeat (FDT_CLKS) @(negedge clk);
      i_tag.send(k ? b : 8'h44, k ? 15 : 3, 1'h0, 9);
      i_tag.send(k ? b : 8'h00, 15, k[0], 9);
      i_tag.finish();
      wait_irq(5, 3000);
      chk("collision", seen[3], !k);
      chk("framing", seen[2], 0);
      chk("parity", seen[1], k);
      chk("crc_err", seen[0], 0);
      chk("rx_count", rx_count, 2);
      chk("rx_bits", rx_last_bits, 0);
      chk("rx_size", rxq.size(), 2);
      if (rxq.size() == 2)
        chk("rx_data", rxq[k ? 0 : 1], k ? b : 8'h00);
      wait_irq(7, 2000);
    end
    cfg.mask_receive_timer = 8'h20;
    cfg.no_response_timer = 16'h0028;
    push_bits(REQA_CODE, 7, 0);
    run_cmd(CMD_REQA);
    wait_irq(6, 4000);
    cmp_tx();
    fork
      i_tag.send(8'hA5, 15, 1'h0, 9);
      for (t = 0; t < 8000 && !rx_active; t++)
        @(negedge clk);
    join
    chk("mask_time", t > 6000 && t < 6080, 1);
    wait_irq(4, 12000);
    chk("early_rx", rxq.size(), 0);
    chk("rx_done", seen[5], 0);
    wait_irq(7, 100);
    // anticollision frame with a split last byte and a split reply
    cfg = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 8'h03, 3'h3, 8'h01, 16'h0100};
    b = 8'($urandom) & 8'h07;
    pay = '{8'h93, 8'h23, b};
    foreach (pay[i])
      put_byte(pay[i]);
    push_a(8'h93);
    push_a(8'h23);
    push_bits(b, 3, 0);
    run_cmd(CMD_TX_NOCRC);
    wait_irq(6, 9000);
    cmp_tx();
    b = 8'($urandom);
    i_tag.send(b, 2, 1'h0, 5);
    i_tag.finish();
    wait_irq(5, 2000);
    chk("split_evt", seen[3:1], 3'h4);
    chk("split_bits", rx_last_bits, 5);
    chk("split_size", rxq.size(), 1);
    if (rxq.size() == 1)
      chk("split_data", rxq[0], b & 8'h1F);
    wait_irq(7, 100);
    // final select with appended crc, no tag answers
    cfg = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h02, 3'h0, 8'h01, 16'h0002};
    pay = '{8'h93, 8'h20};
    crc = crc_calc(pay, 1);
    foreach (pay[i])
      put_byte(pay[i]);
    push_a(8'h93);
    push_a(8'h20);
    push_a(crc[7:0]);
    push_a(crc[15:8]);
    run_cmd(CMD_TX_CRC);
    wait_irq(6, 16000);
    cmp_tx();
    wait_irq(4, 2000);
    chk("sel_end", seen[5:4], 2'h1);
    wait_irq(7, 100);
    for (int s = 0; s < 4; s++)
    begin
      n = s ? 1 : 4;
      cfg = '{1'h1, 1'h1, 1'h0, 1'h0, s[1], s[0], n[7:0], 3'h0, 8'h01, 16'h0002};
      pay.delete();
      for (int i = 0; i < n; i++)
        pay.push_back(8'($urandom));
      foreach (pay[i])
        put_byte(pay[i]);
      if (s == 0)
        chk("fifo_full", host_ready, 0);
      for (int i = 0; i < PRE[s]; i++)
        exq.push_back(1'h0);
      pay.push_front(8'(n + 1));
      crc = crc_calc(pay, 0);
      push_bits(SYNC_FIRST, 8, 1);
      push_bits(SYNC_SECOND, 8, 1);
      foreach (pay[i])
        push_bits(pay[i], 8, 1);
      push_bits(crc[15:8], 8, 1);
      push_bits(crc[7:0], 8, 1);
      run_cmd(CMD_TX_CRC);
      wait_irq(6, 25000);
      cmp_tx();
      chk("drained", host_ready, 1);
      wait_irq(7, 2000);
    end
    report_and_stop();
  end
endmodule : nfc_reader_anticollision_framer_test
